/* sdb_pkg.sv */
// Shared constants, types and helpers for the burst-rule DRAM link.
// Assumes both ends run on one common clock of 200 MHz.
package sdb_pkg;

  // ****************************************
  // Link widths
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int BA_W = 2;
  localparam int NBANK = 4;
  localparam int DQ_W = 32;
  localparam int IDX_W = 8;
  localparam int MEM_WORDS = 256;
  localparam int SR_DEPTH = 16;
  localparam int WBUF = 4;

  // ****************************************
  // Command codes {ras_n, cas_n, we_n}
  // ****************************************
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // ****************************************
  // Mode fields carried on the address pins
  // ****************************************
  localparam int MR_BURST_LSB = 0;
  localparam int MR_CAS_LSB = 4;
  localparam int EMR_ADD_LSB = 3;
  localparam int AP_BIT = 10;
  localparam int COL_LSB = 1;
  localparam logic [2:0] BURST8_CODE = 3'h3;
  localparam logic [1:0] BA_MR = 2'h0;
  localparam logic [1:0] BA_EMR = 2'h1;
  localparam logic [3:0] CAS_RST = 4'h3;
  localparam logic [3:0] ADD_RST = 4'h0;

  // ****************************************
  // Controller registers (byte offsets)
  // ****************************************
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h20;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_ADDR_LSB = 6;
  localparam int CMD_REP_LSB = 19;
  localparam int CTRL_TERM = 0;
  localparam int CTRL_CLR = 1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 5;
  localparam int TERM_OFF_CK = 3;
  localparam int XSNR_NS = 140;
  localparam int XSNR_CK = (XSNR_NS + CLK_NS - 1) / CLK_NS;
  localparam int XSRD_CK = 200;

  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_PRE, OP_RD, OP_WR, OP_MRS, OP_EMRS, OP_SRE, OP_SRX
  } sdb_op_t;

  function automatic logic [3:0] read_lat(logic [3:0] add_lat,
                                          logic [3:0] cas_lat);
    return 4'(add_lat + cas_lat);
  endfunction

  function automatic logic [2:0] burst_words(logic burst8);
    return burst8 ? 3'h4 : 3'h2;
  endfunction

endpackage

/* sdb_link_if.sv */
// Command, address and data pins between controller and DRAM device.
// Assumes one shared clock given to both ends by the bench.
`timescale 1ns/1ps
`default_nettype none
interface sdb_link_if;
  import sdb_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic on_die_termination_control;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] a;
  logic [DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic [DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [DQ_W-1:0] dq;

  // Resolved data bus; idle bus reads as zero
  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);

  modport dev (input cke, cs_n, ras_n, cas_n, we_n,
               input on_die_termination_control, ba, a, dq,
               output dev_dq_o, dev_dq_oe);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n,
               output on_die_termination_control, ba, a,
               output ctl_dq_o, ctl_dq_oe, input dq);
endinterface
`default_nettype wire

/* sdb_dram_dev.sv */
// DRAM device end: decodes link commands, keeps bank and mode state,
// streams read and write bursts. Assumes controller honours its timing.
`timescale 1ns/1ps
`default_nettype none
module sdb_dram_dev import sdb_pkg::*; (
  input wire logic CLK,
  input wire logic NRST,
  sdb_link_if.dev LINK,
  output logic SELF_REFRESH,
  output logic TERM_ON,
  output logic [NBANK-1:0] BANKS_OPEN,
  output logic CMD_REJECT
);

  // ****************************************
  // Decode
  // ****************************************
  logic [DQ_W-1:0] mem [0:MEM_WORDS-1];
  logic [2:0] cmd;
  logic live, is_rd, is_wr, srf_q, burst8_q, rej_q, term_q, oe_q;
  logic [3:0] column_access_latency_q, additive_latency_q;
  logic [3:0] read_latency, write_latency;
  logic [NBANK-1:0] open_q;
  logic [IDX_W-1:0] idx, ridx_q, widx_q, wr_addr;
  logic [2:0] rlft_q, wlft_q, words;
  logic [DQ_W-1:0] dq_q;
  logic wr_en;
  // Entry: {read, write, word index}
  logic [IDX_W+1:0] sr_q [0:SR_DEPTH-1];
  logic [IDX_W+1:0] rtap, wtap;

  assign cmd = {LINK.ras_n, LINK.cas_n, LINK.we_n};
  assign live = LINK.cke && !LINK.cs_n && !srf_q;
  assign idx = {LINK.ba, LINK.a[COL_LSB +: IDX_W-BA_W]};
  assign is_rd = live && cmd == CMD_RD && open_q[LINK.ba]; // [RQ3] [RQ11]
  assign is_wr = live && cmd == CMD_WR && open_q[LINK.ba]; // [RQ3] [RQ11]
  assign read_latency = read_lat(additive_latency_q,
                                 column_access_latency_q); // [RQ10]
  assign write_latency = 4'(read_latency - 4'h1); // [RQ9]
  assign words = burst_words(burst8_q);
  assign rtap = sr_q[4'(read_latency - 4'h1)];
  assign wtap = sr_q[write_latency];

  // ****************************************
  // Bank, mode and power state
  // ****************************************
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      open_q <= '0;
      burst8_q <= 1'b0;
      column_access_latency_q <= CAS_RST;
      additive_latency_q <= ADD_RST;
      srf_q <= 1'b0;
      rej_q <= 1'b0;
      term_q <= 1'b0;
    end else begin
      // Reads and writes to idle banks are dropped
      rej_q <= live && (cmd == CMD_RD || cmd == CMD_WR) &&
               !open_q[LINK.ba]; // [RQ11]
      term_q <= LINK.on_die_termination_control && !srf_q;
      if (srf_q && LINK.cke) begin
        srf_q <= 1'b0;
      end else if (!srf_q && !LINK.cke && !LINK.cs_n &&
                   cmd == CMD_REF && open_q == '0) begin
        srf_q <= 1'b1;
      end
      if (live) begin
        case (cmd)
          CMD_ACT: open_q[LINK.ba] <= 1'b1;
          CMD_PRE: begin
            if (LINK.a[AP_BIT]) open_q <= '0;
            else open_q[LINK.ba] <= 1'b0;
          end
          CMD_MRS: begin
            if (LINK.ba == BA_MR) begin
              burst8_q <= LINK.a[MR_BURST_LSB +: 3] == BURST8_CODE;
              column_access_latency_q <= {1'b0, LINK.a[MR_CAS_LSB +: 3]};
            end else if (LINK.ba == BA_EMR) begin
              additive_latency_q <= {1'b0, LINK.a[EMR_ADD_LSB +: 3]};
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // Latency line
  // ****************************************
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < SR_DEPTH; i++) sr_q[i] <= '0;
    end else begin
      sr_q[0] <= {is_rd, is_wr, idx};
      for (int i = 1; i < SR_DEPTH; i++) sr_q[i] <= sr_q[i-1];
    end
  end

  // ****************************************
  // Read burst engine
  // ****************************************
  // A new tap restarts the engine, so bursts every words clocks abut
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ridx_q <= '0;
      rlft_q <= '0;
      oe_q <= 1'b0;
      dq_q <= '0;
    end else if (rtap[IDX_W+1]) begin
      dq_q <= mem[rtap[IDX_W-1:0]]; // [RQ10] [RQ1]
      ridx_q <= 8'(rtap[IDX_W-1:0] + 8'h1);
      rlft_q <= 3'(words - 3'h1);
      oe_q <= 1'b1;
    end else if (rlft_q != '0) begin
      dq_q <= mem[ridx_q]; // [RQ1]
      ridx_q <= 8'(ridx_q + 8'h1);
      rlft_q <= 3'(rlft_q - 3'h1);
      oe_q <= 1'b1;
    end else begin
      oe_q <= 1'b0;
    end
  end

  // ****************************************
  // Write burst engine
  // ****************************************
  assign wr_en = wtap[IDX_W] || wlft_q != '0; // [RQ2]
  assign wr_addr = wtap[IDX_W] ? wtap[IDX_W-1:0] : widx_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      widx_q <= '0;
      wlft_q <= '0;
    end else if (wtap[IDX_W]) begin
      widx_q <= 8'(wtap[IDX_W-1:0] + 8'h1); // [RQ9]
      wlft_q <= 3'(words - 3'h1);
    end else if (wlft_q != '0) begin
      widx_q <= 8'(widx_q + 8'h1);
      wlft_q <= 3'(wlft_q - 3'h1);
    end
  end

  // Storage array has no reset
  always_ff @(posedge CLK) begin
    if (wr_en) mem[wr_addr] <= LINK.dq;
  end

  assign LINK.dev_dq_o = dq_q;
  assign LINK.dev_dq_oe = oe_q;
  assign SELF_REFRESH = srf_q;
  assign TERM_ON = term_q;
  assign BANKS_OPEN = open_q;
  assign CMD_REJECT = rej_q;

endmodule // sdb_dram_dev
`default_nettype wire

/* sdb_dram_ctl.sv */
// Memory controller end: APB register slave that sequences link
// commands, trains gapless bursts and guards self refresh timing.
// Assumes an APB master on the same clock as the link.
//
// Overview of operation
// RQ1: Reads issue every burst_length/2 clocks, gapless
// RQ2: Writes issue every burst_length/2 clocks, gapless
// RQ3: Gapless bursts over any active banks
// RQ4: Self refresh entry only with banks idle
// RQ5: Termination off turn-off delay before entry
// RQ6: Termination back only after exit-to-read delay
// RQ7: Reads wait exit-to-read delay after exit
// RQ8: Other commands wait exit-to-non-read delay
// RQ9: Write latency is read latency minus one
// RQ10: Read latency is additive plus column latency
// RQ11: No read or write to idle bank
`timescale 1ns/1ps
`default_nettype none
module sdb_dram_ctl import sdb_pkg::*; (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  sdb_link_if.ctl LINK
);

  typedef enum {ST_IDLE, ST_TRAIN, ST_DRAIN, ST_TERM_OFF, ST_SELF} sdb_st_t;

  // ****************************************
  // State
  // ****************************************
  sdb_st_t st_q;
  sdb_op_t op_q;
  logic [BA_W-1:0] bank_q, ba_q;
  logic [ADDR_W-1:0] addr_q, a_q;
  logic [3:0] reps_q, column_access_latency_q, additive_latency_q;
  logic [3:0] read_latency, write_latency;
  logic [2:0] cmd_q, words;
  logic go_q, cke_q, cs_n_q, term_q, term_req_q, burst8_q, err_q, err_p_q;
  logic [NBANK-1:0] open_q;
  logic [7:0] tmr_q, xsrd_q, xsnr_q;
  logic [31:0] wdata_q [0:WBUF-1];
  logic [31:0] rdata_q [0:WBUF-1];
  logic [1:0] csr_q [0:SR_DEPTH-1];
  logic [1:0] widx_q, ridx_q;
  logic [2:0] wlft_q, rlft_q;
  logic [DQ_W-1:0] dq_q;
  logic oe_q, pready_q, pslverr_q, busy, acc, wr_acc, cmd_wr, ok_reg;
  logic [31:0] prdata_q, rd_mux;

  assign read_latency = read_lat(additive_latency_q,
                                 column_access_latency_q); // [RQ10]
  assign write_latency = 4'(read_latency - 4'h1); // [RQ9]
  assign words = burst_words(burst8_q);
  // Self refresh must still take the exit order, so it is not busy
  assign busy = go_q || (st_q != ST_IDLE && st_q != ST_SELF);
  assign acc = PSEL && PENABLE && pready_q;
  assign wr_acc = acc && PWRITE && ok_reg;
  assign cmd_wr = wr_acc && PADDR == REG_CMD;

  // ****************************************
  // Command sequencer
  // ****************************************
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= ST_IDLE;
      op_q <= OP_NOP;
      go_q <= 1'b0;
      bank_q <= '0;
      addr_q <= '0;
      reps_q <= '0;
      cke_q <= 1'b1;
      cs_n_q <= 1'b1;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      a_q <= '0;
      open_q <= '0;
      burst8_q <= 1'b0;
      column_access_latency_q <= CAS_RST;
      additive_latency_q <= ADD_RST;
      tmr_q <= '0;
      xsrd_q <= '0;
      xsnr_q <= '0;
      err_p_q <= 1'b0;
    end else begin
      cs_n_q <= 1'b1;
      cmd_q <= CMD_NOP;
      err_p_q <= 1'b0;
      if (xsrd_q != '0) xsrd_q <= 8'(xsrd_q - 8'h1);
      if (xsnr_q != '0) xsnr_q <= 8'(xsnr_q - 8'h1);
      // Orders written while busy are dropped and flagged
      if (cmd_wr && busy) begin
        err_p_q <= 1'b1;
      end else if (cmd_wr) begin
        go_q <= 1'b1;
        op_q <= sdb_op_t'(PWDATA[3:0]);
        bank_q <= PWDATA[CMD_BANK_LSB +: BA_W];
        addr_q <= PWDATA[CMD_ADDR_LSB +: ADDR_W];
        reps_q <= PWDATA[CMD_REP_LSB +: 4];
      end
      case (st_q)
        ST_IDLE: begin
          if (go_q && op_q == OP_RD && xsrd_q == '0) begin // [RQ7]
            go_q <= 1'b0;
            if (!open_q[bank_q]) err_p_q <= 1'b1; // [RQ11]
            else st_q <= ST_TRAIN;
            tmr_q <= '0;
          end else if (go_q && op_q != OP_RD &&
                       xsnr_q == '0) begin // [RQ8]
            go_q <= 1'b0;
            ba_q <= bank_q;
            a_q <= addr_q;
            case (op_q)
              OP_ACT: begin
                cs_n_q <= 1'b0;
                cmd_q <= CMD_ACT;
                open_q[bank_q] <= 1'b1;
              end
              OP_PRE: begin
                cs_n_q <= 1'b0;
                cmd_q <= CMD_PRE;
                if (addr_q[AP_BIT]) open_q <= '0;
                else open_q[bank_q] <= 1'b0;
              end
              OP_MRS, OP_EMRS: begin
                cs_n_q <= 1'b0;
                cmd_q <= CMD_MRS;
                ba_q <= (op_q == OP_MRS) ? BA_MR : BA_EMR;
                if (op_q == OP_MRS) begin
                  burst8_q <= addr_q[MR_BURST_LSB +: 3] == BURST8_CODE;
                  column_access_latency_q <= {1'b0, addr_q[MR_CAS_LSB +: 3]};
                end else begin
                  additive_latency_q <= {1'b0, addr_q[EMR_ADD_LSB +: 3]};
                end
              end
              OP_WR: begin
                if (!open_q[bank_q]) err_p_q <= 1'b1; // [RQ11]
                else st_q <= ST_TRAIN;
                tmr_q <= '0;
              end
              OP_SRE: begin
                if (open_q != '0) begin
                  err_p_q <= 1'b1; // [RQ4]
                end else begin
                  st_q <= ST_TERM_OFF;
                  tmr_q <= 8'(TERM_OFF_CK); // [RQ5]
                end
              end
              OP_SRX: err_p_q <= 1'b1;
              default: ;
            endcase
          end
        end
        ST_TRAIN: begin
          if (tmr_q == '0) begin
            cs_n_q <= 1'b0;
            cmd_q <= (op_q == OP_RD) ? CMD_RD : CMD_WR; // [RQ1] [RQ2]
            ba_q <= bank_q;
            a_q <= addr_q;
            addr_q <= 13'(addr_q + {words, 1'b0}); // [RQ3]
            tmr_q <= 8'(words - 3'h1); // [RQ1] [RQ2]
            reps_q <= 4'(reps_q - 4'h1);
            if (reps_q == '0) begin
              st_q <= ST_DRAIN;
              tmr_q <= 8'(read_latency + words + 4'h2);
            end
          end else begin
            tmr_q <= 8'(tmr_q - 8'h1);
          end
        end
        ST_DRAIN: begin
          if (tmr_q == '0) st_q <= ST_IDLE;
          else tmr_q <= 8'(tmr_q - 8'h1);
        end
        ST_TERM_OFF: begin
          if (tmr_q == '0) begin
            cke_q <= 1'b0; // [RQ5]
            cs_n_q <= 1'b0;
            cmd_q <= CMD_REF;
            st_q <= ST_SELF;
          end else begin
            tmr_q <= 8'(tmr_q - 8'h1);
          end
        end
        ST_SELF: begin
          if (go_q) begin
            go_q <= 1'b0;
            if (op_q == OP_SRX) begin
              cke_q <= 1'b1;
              xsrd_q <= 8'(XSRD_CK); // [RQ7]
              xsnr_q <= 8'(XSNR_CK); // [RQ8]
              st_q <= ST_IDLE;
            end else begin
              err_p_q <= 1'b1;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Termination control
  // ****************************************
  // Held low from the entry order until the exit-to-read wait ends
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) term_q <= 1'b0;
    else term_q <= term_req_q && st_q != ST_TERM_OFF && st_q != ST_SELF &&
                   !(go_q && op_q == OP_SRE) && xsrd_q == '0; // [RQ5] [RQ6]
  end

  // ****************************************
  // Data engines
  // ****************************************
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < SR_DEPTH; i++) csr_q[i] <= '0;
    end else begin
      csr_q[0] <= {!cs_n_q && cmd_q == CMD_RD, !cs_n_q && cmd_q == CMD_WR};
      for (int i = 1; i < SR_DEPTH; i++) csr_q[i] <= csr_q[i-1];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      widx_q <= '0;
      wlft_q <= '0;
      oe_q <= 1'b0;
      dq_q <= '0;
    end else if (csr_q[4'(write_latency - 4'h1)][0]) begin
      dq_q <= wdata_q[0]; // [RQ9] [RQ2]
      widx_q <= 2'h1;
      wlft_q <= 3'(words - 3'h1);
      oe_q <= 1'b1;
    end else if (wlft_q != '0) begin
      dq_q <= wdata_q[widx_q];
      widx_q <= 2'(widx_q + 2'h1);
      wlft_q <= 3'(wlft_q - 3'h1);
      oe_q <= 1'b1;
    end else begin
      oe_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ridx_q <= '0;
      rlft_q <= '0;
      for (int i = 0; i < WBUF; i++) rdata_q[i] <= '0;
    end else if (csr_q[read_latency][1]) begin
      rdata_q[0] <= LINK.dq; // [RQ10] [RQ1]
      ridx_q <= 2'h1;
      rlft_q <= 3'(words - 3'h1);
    end else if (rlft_q != '0) begin
      rdata_q[ridx_q] <= LINK.dq;
      ridx_q <= 2'(ridx_q + 2'h1);
      rlft_q <= 3'(rlft_q - 3'h1);
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  always_comb begin
    ok_reg = 1'b1;
    rd_mux = '0;
    case (PADDR)
      REG_CMD: rd_mux = '0;
      REG_STAT: rd_mux = {20'h0, read_latency, open_q, 1'b0, err_q,
                          st_q == ST_SELF, busy};
      REG_CTRL: rd_mux = {31'h0, term_req_q};
      REG_WDATA, REG_WDATA + 8'h4, REG_WDATA + 8'h8, REG_WDATA + 8'hc:
        rd_mux = wdata_q[PADDR[3:2]];
      REG_RDATA, REG_RDATA + 8'h4, REG_RDATA + 8'h8, REG_RDATA + 8'hc:
        rd_mux = rdata_q[PADDR[3:2]];
      default: ok_reg = 1'b0;
    endcase
  end

  // One wait state: ready rises on the second access cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= PSEL && PENABLE && !pready_q;
      pslverr_q <= PSEL && PENABLE && !pready_q && !ok_reg;
      if (PSEL && PENABLE && !pready_q) prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      term_req_q <= 1'b0;
      for (int i = 0; i < WBUF; i++) wdata_q[i] <= '0;
    end else if (wr_acc) begin
      if (PADDR == REG_CTRL) term_req_q <= PWDATA[CTRL_TERM];
      if (PADDR[7:4] == REG_WDATA[7:4]) wdata_q[PADDR[3:2]] <= PWDATA;
    end
  end

  // Error flag: a new fault beats a clear in the same cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) err_q <= 1'b0;
    else if (err_p_q) err_q <= 1'b1;
    else if (wr_acc && PADDR == REG_CTRL && PWDATA[CTRL_CLR]) err_q <= 1'b0;
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign LINK.cke = cke_q;
  assign LINK.cs_n = cs_n_q;
  assign {LINK.ras_n, LINK.cas_n, LINK.we_n} = cmd_q;
  assign LINK.ba = ba_q;
  assign LINK.a = a_q;
  assign LINK.on_die_termination_control = term_q;
  assign LINK.ctl_dq_o = dq_q;
  assign LINK.ctl_dq_oe = oe_q;

endmodule // sdb_dram_ctl
`default_nettype wire

/* sdb_link_assertions.sv */
// Checker for the command and data pins between the two link ends.
// Assumes RD_LAT_CK matches the read latency programmed before traffic.
`timescale 1ns/1ps
`default_nettype none
module sdb_link_assertions import sdb_pkg::*; #(
  parameter int RD_LAT_CK = 5
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic on_die_termination_control,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] a,
  input wire logic dev_dq_oe,
  input wire logic ctl_dq_oe
);
  // ****************************************
  // Helper state
  // ****************************************
  localparam int RD_D = RD_LAT_CK + 1;
  localparam int G_RD = RD_LAT_CK - 1;
  localparam int G_WR = RD_LAT_CK - 2;
  logic [2:0] cmd;
  logic v, rd, wr;
  logic [7:0] cnt_q;
  logic [NBANK-1:0] open_q;
  assign cmd = {ras_n, cas_n, we_n};
  assign v = cke & !cs_n;
  assign rd = v && cmd == CMD_RD;
  assign wr = v && cmd == CMD_WR;
  // Saturates so long runs never wrap back into the exit window
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) cnt_q <= 8'hff;
    else if (!cke) cnt_q <= 8'h00;
    else if (cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
  end
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) open_q <= '0;
    else if (v && cmd == CMD_ACT) open_q[ba] <= 1'b1;
    else if (v && cmd == CMD_PRE)
      open_q <= a[AP_BIT] ? '0 : open_q & ~(NBANK'(1) << ba);
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_rd_gap; rd ##1 !v ##1 rd |-> ##G_RD dev_dq_oe [*4]; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read gap");
  property p_wr_gap; wr ##1 !v ##1 wr |-> ##G_WR ctl_dq_oe [*4]; endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write gap");
  property p_idle; $fell(cke) |-> open_q == '0; endproperty
  a_idle: assert property (p_idle) else $error("sre open bank");
  property p_term_off;
    $fell(cke) |-> !on_die_termination_control &&
      !$past(on_die_termination_control, TERM_OFF_CK);
  endproperty
  a_term_off: assert property (p_term_off) else $error("term late");
  property p_term_on;
    on_die_termination_control |-> cnt_q >= 8'(XSRD_CK - 1);
  endproperty
  a_term_on: assert property (p_term_on) else $error("term early");
  property p_xsrd; rd |-> cnt_q >= 8'(XSRD_CK - 1); endproperty
  a_xsrd: assert property (p_xsrd) else $error("read early");
  property p_xsnr;
    v && cmd != CMD_RD && cmd != CMD_NOP |-> cnt_q >= 8'(XSNR_CK - 1);
  endproperty
  a_xsnr: assert property (p_xsnr) else $error("command early");
  property p_wr_lat; wr |-> ##RD_LAT_CK ctl_dq_oe; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write latency");
  property p_rd_lat; rd |-> ##RD_D dev_dq_oe; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read latency");
endmodule // sdb_link_assertions
`default_nettype wire

/* test_sdram_burst_and_self_refresh_rules.sv */
// Self-checking bench: APB drives the controller, device on the link.
// Assumes a 200 MHz clock and the link checker beside the interface.
`timescale 1ns/1ps
`default_nettype none
module test_sdram_burst_and_self_refresh_rules import sdb_pkg::*;;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, erv;
  logic self_ref, term_on, cmd_rej;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [31:0] wd [4];
  logic [NBANK-1:0] banks;
  logic [15:0] seed = 16'h0049;
  logic [5:0] col;
  int num_errors = 0, num_checks = 0, rd_cyc = 0, wr_cyc = 0, rej = 0;
  int c0, nw;
  sdb_link_if link ();
  sdb_dram_dev sdb_dram_dev_inst (.CLK(clk), .NRST(nrst), .LINK(link),
    .SELF_REFRESH(self_ref), .TERM_ON(term_on), .BANKS_OPEN(banks),
    .CMD_REJECT(cmd_rej));
  sdb_dram_ctl sdb_dram_ctl_inst (.CLK(clk), .NRST(nrst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  sdb_link_assertions #(.RD_LAT_CK(5)) sdb_link_assertions_inst (.CLK(clk),
    .NRST(nrst), .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba), .a(link.a),
    .on_die_termination_control(link.on_die_termination_control),
    .dev_dq_oe(link.dev_dq_oe), .ctl_dq_oe(link.ctl_dq_oe));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // Beat counters show missing or extra words in a burst train
  always @(posedge clk) begin
    rd_cyc += link.dev_dq_oe;
    wr_cyc += link.ctl_dq_oe;
    rej += cmd_rej;
  end
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    erv = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
  endtask
  // Waits for busy to drop; exit timers can hold it for 200 clocks
  task automatic cmd(input logic [3:0] op, input logic [1:0] b,
                     input logic [12:0] ad, input logic [3:0] rep);
    int n;
    apb(1, REG_CMD, {9'h0, rep, ad, b, op});
    n = 0;
    do begin
      apb(0, REG_STAT, 32'h0);
      n++;
    end while (rdv[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic rdcheck(input logic [1:0] b);
    c0 = rd_cyc;
    cmd(OP_RD, b, {6'h0, col, 1'b0}, 4'h1);
    chk("read beats", 32'(rd_cyc - c0), 32'(2 * nw));
    for (int i = 0; i < nw; i++) begin
      apb(0, REG_RDATA + 8'(4 * i), 32'h0);
      chk("read word", rdv, wd[i]);
    end
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    nrst = 0;
    repeat (4) @(posedge clk);
    nrst <= 1;
    apb(0, REG_STAT, 32'h0);
    chk("stat reset", rdv, 32'h300);
    apb(0, 8'h40, 32'h0);
    chk("unmapped", 32'(erv), 32'h1);
    cmd(OP_RD, 2'h1, 13'h0, 4'h0);
    apb(0, REG_STAT, 32'h0);
    chk("idle bank", 32'(rdv[2]), 32'h1);
    apb(1, REG_CTRL, 32'h2);
    $display("reset and refusal test done");
    cmd(OP_EMRS, BA_EMR, 13'h10, 4'h0);
    apb(0, REG_STAT, 32'h0);
    chk("latency", 32'(rdv[11:8]), 32'h5);
    cmd(OP_ACT, 2'h0, 13'h0, 4'h0);
    cmd(OP_ACT, 2'h1, 13'h0, 4'h0);
    chk("banks", 32'(banks), 32'h3);
    for (int b8 = 0; b8 < 2; b8++) begin
      nw = b8 ? 4 : 2;
      cmd(OP_MRS, BA_MR, b8 ? 13'h33 : 13'h32, 4'h0);
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < 4; i++) begin
          seed = lfsr(seed);
          wd[i] = {seed, lfsr(seed)};
          apb(1, REG_WDATA + 8'(4 * i), wd[i]);
        end
        col = {1'b0, seed[3:2], 3'h0};
        c0 = wr_cyc;
        cmd(OP_WR, 2'(b), {6'h0, col, 1'b0}, 4'h1);
        chk("write beats", 32'(wr_cyc - c0), 32'(2 * nw));
        rdcheck(2'(b));
      end
      $display("burst test done");
    end
    apb(1, REG_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk("term on", 32'(term_on), 32'h1);
    cmd(OP_SRE, 2'h0, 13'h0, 4'h0);
    apb(0, REG_STAT, 32'h0);
    chk("sre refused", 32'(rdv[2:1]), 32'h2);
    apb(1, REG_CTRL, 32'h3);
    cmd(OP_PRE, 2'h0, 13'h400, 4'h0);
    cmd(OP_SRE, 2'h0, 13'h0, 4'h0);
    chk("in self refresh", 32'({self_ref, term_on}), 32'h2);
    cmd(OP_SRX, 2'h0, 13'h0, 4'h0);
    cmd(OP_ACT, 2'h1, 13'h0, 4'h0);
    rdcheck(2'h1);
    repeat (3) @(posedge clk);
    chk("term back", 32'({self_ref, term_on}), 32'h1);
    chk("rejects", 32'(rej), 32'h0);
    $display("self refresh test done");
    finish_test();
  end
endmodule // test_sdram_burst_and_self_refresh_rules
`default_nettype wire
